// ==== design/dba_dma_end.sv ====
// DMA end: four-channel arbiter, hold handshake, address latch, two-entry buffer
// Overview of operation
// - Channel 0 serves tester, answers tester grant
// - Channel 1 serves delayed floppy request, grants
// - Channels 2,3 serve display; grants combined
// - Pending request raises hold to stop CPU
// - CPU acks idle bus; no transfer before
// - After ack, assert address enable
// - Drive latch on data, pulse strobe; page loads a cycle later
// - Latch holds byte as address 8-15; tester strobe
// - Low address lines input programming, output DMA
// - Terminal count at channel's transfer end
// - At least one wait, more during refresh
// - CPU fetch gets wait states too
// - Memory done releases the waiting master
// - Strobes tri-state, owned by bus master
// - Tester or DMA may raise bus request
// - Runs from one system clock
// - Reset at power-up and front switch
`timescale 1ns/10ps
`default_nettype none
module dba_dma_end
    import dba_pkg::*;
#(
    parameter int XFER_LEN = 4
) (
    input wire logic clk,
    input wire logic resetn,
    dba_bus_if.dma bus,
    input wire logic testerRequest,
    input wire logic floppy_request_delayed,
    input wire logic displayRequestA,
    input wire logic displayRequestB,
    input wire logic tester_latch_strobe,
    input wire logic [DATA_W-1:0] tester_latch_data,
    input wire logic [DATA_W-1:0] srcData,
    input wire logic srcValid,
    output logic srcReady,
    output logic [DATA_W-1:0] sinkData,
    output logic sinkValid,
    input wire logic sinkReady,
    output logic tester_dma_grant,
    output logic floppy_dma_grant,
    output logic display_grant_a,
    output logic display_grant_b,
    output logic display_grant_combined,
    output logic [DATA_W-1:0] highAddr
);
    dba_state_t state_q, state_d;
    logic [1:0] chan_q, chan_d;
    logic [CNT_W-1:0] left_q, left_d;
    logic [CNT_W-1:0] waitCnt_q, waitCnt_d;
    logic [DATA_W-1:0] page_q, page_d;
    logic [LOW_ADDR_W-1:0] low_q, low_d;
    logic [DATA_W-1:0] latch_q, latch_d;
    logic [NUM_CHAN-1:0] grant_q, grant_d;
    logic tc_q, tc_d;
    logic [DATA_W-1:0] buf_q [2];
    logic [DATA_W-1:0] buf_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic [NUM_CHAN-1:0] req;
    logic [NUM_CHAN-1:0] reqS1_q, reqS2_q;
    logic lsS1_q, lsS2_q;
    logic [DATA_W-1:0] ldS1_q, ldS2_q;
    logic push, pop;

    // Two-flop synchronisers for the request and latch pins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reqS1_q <= '0;
            reqS2_q <= '0;
            lsS1_q <= 1'b0;
            lsS2_q <= 1'b0;
            ldS1_q <= BYTE_ZERO;
            ldS2_q <= BYTE_ZERO;
        end else begin
            reqS1_q <= {displayRequestB, displayRequestA, floppy_request_delayed,
                testerRequest};
            reqS2_q <= reqS1_q;
            lsS1_q <= tester_latch_strobe;
            lsS2_q <= lsS1_q;
            ldS1_q <= tester_latch_data;
            ldS2_q <= ldS1_q;
        end
    end
    assign req = reqS2_q;

    assign push = srcValid && srcReady;
    assign pop = sinkValid && sinkReady;

    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        left_d = left_q;
        waitCnt_d = waitCnt_q;
        page_d = page_q;
        low_d = low_q;
        latch_d = latch_q;
        grant_d = '0;
        tc_d = 1'b0;
        // CPU programs page and low address while it owns the bus
        if (bus.dmaChipSel && bus.ioWr && state_q == DBA_IDLE) begin
            page_d = bus.cpuData;
            low_d = bus.cpuLowAddr;
        end
        if (lsS2_q) begin
            latch_d = ldS2_q;
        end
        unique case (state_q)
            DBA_IDLE: begin
                if (|req) begin
                    state_d = DBA_HOLD;
                    left_d = CNT_W'(XFER_LEN);
                    if (req[CH_TESTER]) chan_d = 2'(CH_TESTER);
                    else if (req[CH_FLOPPY]) chan_d = 2'(CH_FLOPPY);
                    else if (req[CH_DISP_A]) chan_d = 2'(CH_DISP_A);
                    else chan_d = 2'(CH_DISP_B);
                end
            end
            DBA_HOLD: begin
                if (bus.holdAck) begin
                    state_d = DBA_ADDR;
                end
            end
            DBA_ADDR: begin
                latch_d = page_q;
                waitCnt_d = CNT_W'(MIN_WAIT);
                state_d = DBA_WAIT;
            end
            DBA_WAIT: begin
                if (waitCnt_q != CNT_ZERO) begin
                    waitCnt_d = waitCnt_q - CNT_ONE;
                end else if (!bus.refreshBusy && !bus.waitDma && bus.memoryCycleDone
                    && cnt_q != 2'd2) begin
                    state_d = DBA_XFER;
                end
            end
            DBA_XFER: begin
                grant_d[chan_q] = 1'b1;
                low_d = low_q + LOW_ADDR_W'(1);
                left_d = left_q - CNT_ONE;
                if (left_q == CNT_ONE) begin
                    tc_d = 1'b1;
                    state_d = DBA_DONE;
                end else begin
                    waitCnt_d = CNT_W'(MIN_WAIT);
                    state_d = DBA_WAIT;
                end
            end
            DBA_DONE: begin
                state_d = DBA_IDLE;
            end
            default: state_d = DBA_IDLE;
        endcase
    end

    // Two-entry buffer; back-pressure stalls the transfer engine
    always_comb begin
        buf_d = buf_q;
        cnt_d = cnt_q;
        if (pop) begin
            buf_d[0] = buf_q[1];
            cnt_d = cnt_d - 2'd1;
        end
        if (push) begin
            // A pop shifts the queue, so the new word lands one slot lower
            buf_d[pop ? int'(cnt_q) - 1 : int'(cnt_q)] = srcData;
            cnt_d = cnt_d + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= DBA_IDLE;
            chan_q <= 2'b00;
            left_q <= CNT_ZERO;
            waitCnt_q <= CNT_ZERO;
            page_q <= BYTE_ZERO;
            low_q <= LOW_ZERO;
            latch_q <= BYTE_ZERO;
            grant_q <= '0;
            tc_q <= 1'b0;
            buf_q[0] <= BYTE_ZERO;
            buf_q[1] <= BYTE_ZERO;
            cnt_q <= 2'b00;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            left_q <= left_d;
            waitCnt_q <= waitCnt_d;
            page_q <= page_d;
            low_q <= low_d;
            latch_q <= latch_d;
            grant_q <= grant_d;
            tc_q <= tc_d;
            buf_q <= buf_d;
            cnt_q <= cnt_d;
        end
    end

    // Bus outputs registered from the next state
    logic own_q, strobe_q, rd_q, hold_q, dataOeN_q, ownN_q, dispComb_q;
    logic srcRdy_q, sinkVld_q;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            own_q <= 1'b0;
            strobe_q <= 1'b0;
            rd_q <= 1'b0;
            hold_q <= 1'b0;
            dataOeN_q <= 1'b1;
            ownN_q <= 1'b1;
            dispComb_q <= 1'b0;
            srcRdy_q <= 1'b0;
            sinkVld_q <= 1'b0;
        end else begin
            own_q <= state_d inside {DBA_ADDR, DBA_WAIT, DBA_XFER};
            strobe_q <= state_d == DBA_ADDR;
            rd_q <= state_d == DBA_XFER;
            hold_q <= state_d != DBA_IDLE;
            dataOeN_q <= state_d != DBA_ADDR;
            ownN_q <= !(state_d inside {DBA_ADDR, DBA_WAIT, DBA_XFER});
            dispComb_q <= |grant_d[CH_DISP_B:CH_DISP_A];
            srcRdy_q <= cnt_d != 2'd2;
            sinkVld_q <= cnt_d != 2'd0;
        end
    end

    assign bus.holdReq = hold_q;
    assign bus.dmaAddrEn = own_q;
    assign bus.addrStrobe = strobe_q;
    assign bus.dmaData = latch_q;
    assign bus.dmaDataOeN = dataOeN_q;
    assign bus.dmaLowAddr = low_q;
    assign bus.dmaLowAddrOeN = ownN_q;
    assign bus.dmaMemRd = rd_q;
    assign bus.dmaMemWr = 1'b0;
    assign bus.dmaStrobeOeN = ownN_q;
    assign bus.terminalCount = tc_q;
    assign srcReady = srcRdy_q;
    assign sinkValid = sinkVld_q;
    assign sinkData = buf_q[0];
    assign tester_dma_grant = grant_q[CH_TESTER];
    assign floppy_dma_grant = grant_q[CH_FLOPPY];
    assign display_grant_a = grant_q[CH_DISP_A];
    assign display_grant_b = grant_q[CH_DISP_B];
    assign display_grant_combined = dispComb_q;
    assign highAddr = latch_q;
endmodule : dba_dma_end
`default_nettype wire

// ==== design/dba_pkg.sv ====
// Shared constants and types for the DMA bus arbitration block
package dba_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int SYS_CLK_HZ = 4000000;
    localparam int NUM_CHAN = 4;
    localparam int CH_TESTER = 0;
    localparam int CH_FLOPPY = 1;
    localparam int CH_DISP_A = 2;
    localparam int CH_DISP_B = 3;
    localparam int LOW_ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int MIN_WAIT = 1;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [LOW_ADDR_W-1:0] LOW_ZERO = 5'h00;

    typedef enum logic [2:0] {
        DBA_IDLE = 3'b000,
        DBA_HOLD = 3'b001,
        DBA_ADDR = 3'b010,
        DBA_WAIT = 3'b011,
        DBA_XFER = 3'b100,
        DBA_DONE = 3'b101
    } dba_state_t;
endpackage : dba_pkg

// ==== design/dba_bus_if.sv ====
// Interface joining the DMA end and the CPU/memory end
`timescale 1ns/10ps
`default_nettype none
interface dba_bus_if;
    import dba_pkg::*;
    logic holdReq;
    logic holdAck;
    logic dmaAddrEn;
    logic addrStrobe;
    logic [DATA_W-1:0] dmaData;
    logic dmaDataOeN;
    logic [LOW_ADDR_W-1:0] dmaLowAddr;
    logic dmaLowAddrOeN;
    logic [LOW_ADDR_W-1:0] cpuLowAddr;
    logic dmaMemRd;
    logic dmaMemWr;
    logic dmaStrobeOeN;
    logic memoryCycleDone;
    logic refreshBusy;
    logic waitDma;
    logic terminalCount;
    logic dmaChipSel;
    logic ioWr;
    logic [DATA_W-1:0] cpuData;

    modport dma (output holdReq, dmaAddrEn, addrStrobe, dmaData, dmaDataOeN, dmaLowAddr,
        dmaLowAddrOeN, dmaMemRd, dmaMemWr, dmaStrobeOeN, terminalCount,
        input holdAck, memoryCycleDone, refreshBusy, waitDma, dmaChipSel, ioWr,
        cpuLowAddr, cpuData);
    modport cpu (input holdReq, dmaAddrEn, addrStrobe, dmaData, dmaDataOeN, dmaLowAddr,
        dmaLowAddrOeN, dmaMemRd, dmaMemWr, dmaStrobeOeN, terminalCount,
        output holdAck, memoryCycleDone, refreshBusy, waitDma, dmaChipSel, ioWr,
        cpuLowAddr, cpuData);
endinterface : dba_bus_if
`default_nettype wire

// ==== design/dba_cpu_end.sv ====
// CPU and memory end: hold acknowledge, wait logic, channel programming
`timescale 1ns/10ps
`default_nettype none
module dba_cpu_end
    import dba_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    dba_bus_if.cpu bus,
    input wire logic cpuBusy,
    input wire logic refreshReq,
    input wire logic memReq,
    input wire logic fetchCycle,
    input wire logic progWrite,
    input wire logic [LOW_ADDR_W-1:0] progAddr,
    input wire logic [DATA_W-1:0] progData,
    output logic cpuWait,
    output logic cpuStrobeOeN,
    output logic dmaOwnsBus
);
    logic ack_q, ack_d, ref_q, ref_d, done_q, done_d, wait_q, wait_d, prog_q, prog_d;
    logic waitDma_q, waitDma_d, own_q, own_d;
    logic [LOW_ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d;

    always_comb begin
        // Acknowledge only an idle bus, then keep it for the whole burst
        ack_d = bus.holdReq && (ack_q || (!cpuBusy && !memReq));
        ref_d = refreshReq;
        done_d = memReq || bus.dmaMemRd;
        wait_d = fetchCycle && (!wait_q || refreshReq);
        waitDma_d = refreshReq;
        prog_d = progWrite && !bus.holdReq;
        own_d = bus.dmaAddrEn;
        addr_d = progAddr;
        data_d = progData;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            ref_q <= 1'b0;
            done_q <= 1'b0;
            wait_q <= 1'b0;
            prog_q <= 1'b0;
            waitDma_q <= 1'b0;
            own_q <= 1'b0;
            addr_q <= LOW_ZERO;
            data_q <= BYTE_ZERO;
        end else begin
            ack_q <= ack_d;
            ref_q <= ref_d;
            done_q <= done_d;
            wait_q <= wait_d;
            prog_q <= prog_d;
            waitDma_q <= waitDma_d;
            own_q <= own_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    assign bus.holdAck = ack_q;
    assign bus.refreshBusy = ref_q;
    assign bus.memoryCycleDone = done_q;
    assign bus.waitDma = waitDma_q;
    assign bus.dmaChipSel = prog_q;
    assign bus.ioWr = prog_q;
    assign bus.cpuLowAddr = addr_q;
    assign bus.cpuData = data_q;
    assign cpuWait = wait_q;
    assign cpuStrobeOeN = own_q;
    assign dmaOwnsBus = own_q;
endmodule : dba_cpu_end
`default_nettype wire

// ==== sim/dba_properties.sv ====
// Interface checks between the DMA end and the CPU end
`timescale 1ns/10ps
`default_nettype none
module dba_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic holdReq,
    input wire logic holdAck,
    input wire logic dmaAddrEn,
    input wire logic addrStrobe,
    input wire logic dmaDataOeN,
    input wire logic dmaLowAddrOeN,
    input wire logic dmaMemRd,
    input wire logic dmaStrobeOeN,
    input wire logic terminalCount
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ack_bound_a: assert property ($rose(holdReq) |-> ##[1:300] holdAck)
        else $error("hold not acknowledged");
    ack_first_a: assert property (dmaMemRd |-> holdAck)
        else $error("transfer without acknowledge");
    addr_take_a: assert property ($rose(holdAck) |-> ##1 (addrStrobe && dmaAddrEn))
        else $error("no address enable after acknowledge");
    strobe_pulse_a: assert property (addrStrobe |=> !addrStrobe)
        else $error("address strobe too long");
    page_drive_a: assert property (addrStrobe |-> !dmaDataOeN)
        else $error("page not driven on data bus");
    low_out_a: assert property (!dmaLowAddrOeN |-> holdReq)
        else $error("low address driven outside DMA");
    tc_pulse_a: assert property (terminalCount |=> !terminalCount)
        else $error("terminal count too long");
    tc_hold_a: assert property (terminalCount |-> holdReq)
        else $error("terminal count outside DMA");
    wait_gap_a: assert property (dmaMemRd |=> !dmaMemRd)
        else $error("no wait state between units");
    strobe_own_a: assert property (!dmaStrobeOeN |-> holdReq)
        else $error("strobes driven without bus");
    cover property ($rose(holdAck));
    cover property (terminalCount);
    cover property (dmaMemRd && holdAck);
endmodule : dba_properties
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench joining both ends of the arbitration block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dba_pkg::*;
    localparam int XL = 3;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] req = 4'h0;
    logic tStb = 1'b0;
    logic [7:0] tDat = 8'h00;
    logic [7:0] srcData = 8'h00;
    logic srcValid = 1'b0;
    logic sinkReady = 1'b0;
    logic cpuBusy = 1'b0;
    logic refreshReq = 1'b0;
    logic memReq = 1'b0;
    logic fetchCycle = 1'b0;
    logic progWrite = 1'b0;
    logic [4:0] progAddr = 5'h00;
    logic [7:0] progData = 8'h00;
    logic srcReady;
    logic sinkValid;
    logic [7:0] sinkData;
    logic [7:0] hA;
    logic [4:0] gr;
    logic cWait, cOeN, cOwn;
    logic pFetch = 1'b0, pWait = 1'b0, pAen = 1'b0, pRst = 1'b0;
    logic [31:0] rs = 32'h97D5;
    logic [7:0] gq[$];
    logic [7:0] dq[$];
    int fails = 0;
    int checkCount = 0;

    dba_bus_if dba_bus_if_i ();
    dba_dma_end #(.XFER_LEN(XL)) dba_dma_end_i (.clk(clk), .resetn(resetn), .bus(dba_bus_if_i),
        .testerRequest(req[0]), .floppy_request_delayed(req[1]), .displayRequestA(req[2]),
        .displayRequestB(req[3]), .tester_latch_strobe(tStb), .tester_latch_data(tDat),
        .srcData(srcData), .srcValid(srcValid), .srcReady(srcReady), .sinkData(sinkData),
        .sinkValid(sinkValid), .sinkReady(sinkReady), .tester_dma_grant(gr[0]),
        .floppy_dma_grant(gr[1]), .display_grant_a(gr[2]), .display_grant_b(gr[3]),
        .display_grant_combined(gr[4]), .highAddr(hA));
    dba_cpu_end dba_cpu_end_i (.clk(clk), .resetn(resetn), .bus(dba_bus_if_i),
        .cpuBusy(cpuBusy), .refreshReq(refreshReq), .memReq(memReq), .fetchCycle(fetchCycle),
        .progWrite(progWrite), .progAddr(progAddr), .progData(progData), .cpuWait(cWait),
        .cpuStrobeOeN(cOeN), .dmaOwnsBus(cOwn));
    dba_properties dba_properties_i (.clk(clk), .resetn(resetn),
        .holdReq(dba_bus_if_i.holdReq), .holdAck(dba_bus_if_i.holdAck),
        .dmaAddrEn(dba_bus_if_i.dmaAddrEn), .addrStrobe(dba_bus_if_i.addrStrobe),
        .dmaDataOeN(dba_bus_if_i.dmaDataOeN), .dmaLowAddrOeN(dba_bus_if_i.dmaLowAddrOeN),
        .dmaMemRd(dba_bus_if_i.dmaMemRd), .dmaStrobeOeN(dba_bus_if_i.dmaStrobeOeN),
        .terminalCount(dba_bus_if_i.terminalCount));

    always #20 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d fails %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic waitFor(ref logic s, input logic v, input string nm);
        int n;
        n = 0;
        while (s !== v && n < 500) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, s}, {7'h0, v}, nm);
    endtask : waitFor

    // Requests stay up until hold is raised for them, then drop
    task automatic run(input logic [3:0] m);
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < XL && m[c]; n++) gq.push_back(8'h01 << c | (c > 1 ? 8'h10 : 8'h00));
        @(posedge clk) req <= m;
        for (int c = 0; c < 4; c++) begin
            if (m[c]) begin
                waitFor(dba_bus_if_i.holdReq, 1'b1, "hold");
                @(posedge clk) req[c] <= 1'b0;
                waitFor(dba_bus_if_i.terminalCount, 1'b1, "tc");
                waitFor(dba_bus_if_i.holdReq, 1'b0, "release");
            end
        end
    endtask : run

    // Random stimulus for the CPU side and the buffer
    always @(posedge clk) begin
        rs <= xs(rs);
        cpuBusy <= rs[1:0] == 2'h0;
        refreshReq <= rs[4:2] == 3'h0;
        memReq <= rs[5];
        fetchCycle <= rs[6];
        sinkReady <= rs[7] | rs[8];
        if (resetn && srcValid && srcReady) dq.push_back(srcData);
        if (!srcValid || srcReady) begin
            srcValid <= rs[9] & resetn;
            srcData <= rs[17:10];
        end
    end

    always @(posedge clk) begin
        if (resetn && |gr) chk({3'h0, gr}, gq.size() ? gq.pop_front() : 8'hFF, "grant");
        if (resetn && sinkValid && sinkReady) chk(sinkData, dq.size() ? dq.pop_front() : ~sinkData, "sink");
        if (resetn && pRst) chk({7'h0, cOwn}, {7'h0, pAen}, "own");
        if (resetn && pRst) chk({7'h0, cOeN}, {7'h0, pAen}, "cpuoe");
        if (resetn && pRst && pFetch && !pWait) chk({7'h0, cWait}, 8'h01, "wait");
        pAen <= dba_bus_if_i.dmaAddrEn;
        pFetch <= fetchCycle;
        pWait <= cWait;
        pRst <= resetn;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        progWrite <= 1'b1;
        progAddr <= 5'h13;
        progData <= 8'hA5;
        @(posedge clk) progWrite <= 1'b0;
        repeat (6) @(negedge clk);
        @(posedge clk) tDat <= 8'h3C;
        tStb <= 1'b1;
        repeat (3) @(posedge clk);
        tStb <= 1'b0;
        repeat (6) @(negedge clk);
        chk(hA, 8'h3C, "latch");
        run(4'h1);
        chk(hA, 8'hA5, "page");
        chk({3'h0, dba_bus_if_i.dmaLowAddr}, 8'h16, "low");
        run(4'h2);
        run(4'h4);
        run(4'h8);
        run(4'hF);
        run(4'hC);
        repeat (20) @(posedge clk);
        chk(8'(gq.size()), 8'h00, "left");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
